// *** design/ssld_pkg.sv ***
package ssld_pkg;

	// ---------------------------------------------------------------
	// shift register geometry
	// ---------------------------------------------------------------
	localparam int          SR_W        = 12;
	localparam int          FIRST_STAGE = 11;
	localparam int          LAST_STAGE  = 0;
	localparam int          SYN_HI      = 11;
	localparam int          SYN_LO      = 4;
	localparam logic [11:0] SR_RESET    = 12'h000;
	localparam logic [7:0]  SYN_CODE    = 8'h16;

	// ---------------------------------------------------------------
	// frame size register
	// ---------------------------------------------------------------
	localparam int          FS_W        = 4;
	localparam logic [3:0]  FS_RESET    = 4'h8;
	localparam logic [3:0]  EXT_IDLE    = 4'h0;

	// ---------------------------------------------------------------
	// pin synchroniser lanes
	// ---------------------------------------------------------------
	localparam int          PIN_W       = 6;
	localparam int          PIN_RCLK    = 0;
	localparam int          PIN_TCLK    = 1;
	localparam int          PIN_RXD     = 2;
	localparam int          PIN_CTS     = 3;
	localparam int          PIN_DSR     = 4;
	localparam int          PIN_DCD     = 5;
	localparam logic [5:0]  PIN_RESET   = 6'h00;

endpackage

// *** design/ssld_sync.sv ***
`timescale 1ns/10ps
module ssld_sync
	import ssld_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [PIN_W-1:0] d,
	output logic      [PIN_W-1:0] q
);

	// ---------------------------------------------------------------
	// two-stage synchroniser, first stage read only by the second
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [PIN_W-1:0] meta;
		logic [PIN_W-1:0] stable;
	} ssld_sync_st_t;

	ssld_sync_st_t st_reg;
	ssld_sync_st_t st_next;

	always_comb begin
		st_next        = st_reg;
		st_next.meta   = d;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= {PIN_RESET, PIN_RESET};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.stable;

endmodule

// *** design/ssld_top.sv ***
// Overview of operation
// - characters live in a twelve-stage shift register, first stage high-order.
// - in receive, each line bit shifts into the first stage on the strobe.
// - in transmit, the last stage shifts into the line output buffer flop.
// - the memory load strobe loads the buffered memory word into the register.
// - in transmit the memory load strobe ORs ones onto the cleared register.
// - receive uses the modem receive clock, transmit the modem transmit clock.
// - the first stage clear is driven separately from the other stages' clear.
// - in transmit, frame overflow clears the whole register before the next load.
// - in receive, the register clears once the storing transfer completes.
// - on sync match, clear all but first stage and take the line bit.
// - outside receive, zeros are shifted in rather than line data.
// - an output select flop picks shifted data or parity for the line.
// - in receive the transmit line is held at zero.
// - transmit and receive state flops change on clock edges from synced modem inputs plus unsynced RTS and terminal ready.
// - a latch keeps the last receive character interrupt after receive ends.
// - a four-bit register holds the modulo-16 complement of character length.
// - software writes the frame size from the accumulator and reads it back.
// - only the SYN code is recognised as the character sync pattern.
// - transmit state needs RTS, CTS, set ready, terminal ready and carrier.
// - frame counter overflow ends a character, reloaded from the frame size.
// - sync is found when the first eight stages equal the SYN code.
`timescale 1ns/10ps
module ssld_top
	import ssld_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            rst_n,
	input  wire logic            modem_receive_clock,
	input  wire logic            modem_transmit_clock,
	input  wire logic            receive_line,
	input  wire logic            clear_to_send,
	input  wire logic            set_ready,
	input  wire logic            carrier_detect,
	input  wire logic            request_to_send,
	input  wire logic            terminal_ready,
	input  wire logic            sync_hunt,
	input  wire logic            memory_load_strobe,
	input  wire logic [SR_W-1:0] memory_word,
	input  wire logic            transfer_done,
	input  wire logic            frame_overflow,
	input  wire logic            parity_bit,
	input  wire logic            parity_select,
	input  wire logic            int_clear,
	input  wire logic            io_write,
	input  wire logic            io_read,
	input  wire logic [FS_W-1:0] acc_in,
	output logic      [SR_W-1:0] serdes_register,
	output logic                 transmit_line,
	output logic                 transmit_state_ff,
	output logic                 receive_state_ff,
	output logic                 last_interrupt_latch,
	output logic                 sync_match,
	output logic                 shift_strobe,
	output logic      [FS_W-1:0] frame_size_field,
	output logic      [FS_W-1:0] extended_acc_bus
);

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n   <= rst_meta_reg;
		end
	end

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_s;

	assign pins_raw = {carrier_detect, set_ready, clear_to_send,
	                   receive_line, modem_transmit_clock, modem_receive_clock};

	ssld_sync ssld_sync_inst (
		.core_clk (core_clk),
		.rst_n    (rst_sync_n),
		.d        (pins_raw),
		.q        (pins_s)
	);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [SR_W-1:0] sr;
		logic            rclk_prev;
		logic            tclk_prev;
		logic            tx_st;
		logic            rx_st;
		logic            lob;
		logic            pbb;
		logic            out_sel;
		logic            tline;
		logic            last_int;
		logic            hit;
		logic            strobe;
		logic [FS_W-1:0] fs;
		logic [FS_W-1:0] ext_bus;
	} ssld_st_t;

	localparam ssld_st_t ST_RESET = '{
		sr: SR_RESET, rclk_prev: 1'b0, tclk_prev: 1'b0, tx_st: 1'b0,
		rx_st: 1'b0, lob: 1'b0, pbb: 1'b0, out_sel: 1'b0, tline: 1'b0,
		last_int: 1'b0, hit: 1'b0, strobe: 1'b0, fs: FS_RESET, ext_bus: EXT_IDLE
	};

	ssld_st_t st_reg;
	ssld_st_t st_next;

	logic            tx_cond;
	logic            rx_cond;
	logic            shift;
	logic            serial_in;
	logic            syn_seen;
	logic            hit;
	logic            clr_first;
	logic            clr_rest;
	logic            load;
	logic [SR_W-1:0] shifted;

	always_comb begin
		tx_cond = request_to_send && pins_s[PIN_CTS] && pins_s[PIN_DSR]
		          && terminal_ready && pins_s[PIN_DCD];
		rx_cond = !request_to_send && !pins_s[PIN_CTS] && pins_s[PIN_DSR]
		          && pins_s[PIN_DCD];
		// one strobe per rising edge
		// each clock keeps its own history so a state change makes no false edge
		if (st_reg.rx_st) begin
			shift = pins_s[PIN_RCLK] && !st_reg.rclk_prev;
		end else if (st_reg.tx_st) begin
			shift = pins_s[PIN_TCLK] && !st_reg.tclk_prev;
		end else begin
			shift = 1'b0;
		end
		serial_in = st_reg.rx_st ? pins_s[PIN_RXD] : 1'b0;
		syn_seen  = (st_reg.sr[SYN_HI:SYN_LO] == SYN_CODE);
		hit       = st_reg.rx_st && sync_hunt && shift && syn_seen && !transfer_done;
		// split clears of first stage and the rest
		clr_first = (st_reg.tx_st && frame_overflow) || (st_reg.rx_st && transfer_done);
		clr_rest  = clr_first || hit;
		load      = memory_load_strobe && !clr_first;
		shifted   = {serial_in, st_reg.sr[SR_W-1:1]};
	end

	always_comb begin
		st_next           = st_reg;
		st_next.rclk_prev = pins_s[PIN_RCLK];
		st_next.tclk_prev = pins_s[PIN_TCLK];
		st_next.strobe    = shift;
		st_next.hit       = hit;
		// state flops only move on the clock, from synced CTS, set ready and carrier plus unsynced RTS and terminal ready
		st_next.tx_st     = tx_cond;
		st_next.rx_st     = rx_cond;

		// first stage
		if (clr_first) begin
			st_next.sr[FIRST_STAGE] = 1'b0;
		end else if (load && st_reg.tx_st) begin
			st_next.sr[FIRST_STAGE] = st_reg.sr[FIRST_STAGE] | memory_word[FIRST_STAGE];
		end else if (load) begin
			st_next.sr[FIRST_STAGE] = memory_word[FIRST_STAGE];
		end else if (shift) begin
			// line bit taken on the sync clock
			// incoming bit enters the first stage
			st_next.sr[FIRST_STAGE] = serial_in;
		end

		// remaining stages
		if (clr_rest) begin
			// all but first cleared on sync
			st_next.sr[FIRST_STAGE-1:0] = SR_RESET[FIRST_STAGE-1:0];
		end else if (load && st_reg.tx_st) begin
			st_next.sr[FIRST_STAGE-1:0] = st_reg.sr[FIRST_STAGE-1:0]
			                              | memory_word[FIRST_STAGE-1:0];
		end else if (load) begin
			st_next.sr[FIRST_STAGE-1:0] = memory_word[FIRST_STAGE-1:0];
		end else if (shift) begin
			st_next.sr[FIRST_STAGE-1:0] = shifted[FIRST_STAGE-1:0];
		end

		if (st_reg.tx_st && shift) begin
			st_next.lob     = st_reg.sr[LAST_STAGE];
			// select and parity sampled on the bit boundary
			st_next.pbb     = parity_bit;
			st_next.out_sel = parity_select;
		end

		// data or parity onto the line
		if (st_reg.rx_st) begin
			st_next.tline = 1'b0;
		end else begin
			st_next.tline = st_reg.out_sel ? st_reg.pbb : st_reg.lob;
		end

		// set wins over clear, survives end of receive
		if (st_reg.rx_st && frame_overflow) begin
			st_next.last_int = 1'b1;
		end else if (int_clear) begin
			st_next.last_int = 1'b0;
		end

		// loaded from the accumulator, read on the extended bus
		if (io_write) begin
			st_next.fs = acc_in;
		end
		st_next.ext_bus = io_read ? st_reg.fs : EXT_IDLE;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign serdes_register      = st_reg.sr;
	assign transmit_line        = st_reg.tline;
	assign transmit_state_ff    = st_reg.tx_st;
	assign receive_state_ff     = st_reg.rx_st;
	assign last_interrupt_latch = st_reg.last_int;
	assign sync_match           = st_reg.hit;
	assign shift_strobe         = st_reg.strobe;
	// frame size feeds the external frame counter reload
	assign frame_size_field     = st_reg.fs;
	assign extended_acc_bus     = st_reg.ext_bus;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	property p_tx_clear;
		st_reg.tx_st && frame_overflow |=> st_reg.sr == SR_RESET;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx overflow did not clear");

	property p_rx_clear;
		st_reg.rx_st && transfer_done |=> st_reg.sr == SR_RESET;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("rx store did not clear");

	property p_or_load;
		st_reg.tx_st && memory_load_strobe && !frame_overflow
		|=> st_reg.sr == ($past(st_reg.sr) | $past(memory_word));
	endproperty
	a_or_load: assert property (p_or_load) else $error("transmit load not ORed");

	property p_shift_in;
		st_reg.rx_st && shift && !transfer_done && !hit && !memory_load_strobe
		|=> st_reg.sr == {$past(pins_s[PIN_RXD]), $past(st_reg.sr[SR_W-1:1])};
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("receive shift wrong");

	property p_sync_clear;
		hit && !memory_load_strobe
		|=> st_reg.sr[FIRST_STAGE-1:0] == SR_RESET[FIRST_STAGE-1:0]
		    && st_reg.sr[FIRST_STAGE] == $past(pins_s[PIN_RXD]) && sync_match;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync clear wrong");

	property p_zero_in;
		!st_reg.rx_st && shift && !clr_first && !memory_load_strobe
		|=> !st_reg.sr[FIRST_STAGE];
	endproperty
	a_zero_in: assert property (p_zero_in) else $error("nonzero shifted in");

	property p_line_buf;
		st_reg.tx_st && shift |=> st_reg.lob == $past(st_reg.sr[LAST_STAGE])
		                          ##1 (st_reg.rx_st || transmit_line ==
		                               (st_reg.out_sel ? $past(st_reg.pbb) : $past(st_reg.lob)));
	endproperty
	a_line_buf: assert property (p_line_buf) else $error("line buffer wrong");

	property p_quiet;
		st_reg.rx_st |=> !transmit_line;
	endproperty
	a_quiet: assert property (p_quiet) else $error("line active in receive");

	property p_state_excl;
		!(st_reg.tx_st && st_reg.rx_st) and (st_reg.tx_st |-> $past(tx_cond));
	endproperty
	a_state_excl: assert property (p_state_excl) else $error("state flops wrong");

	property p_latch;
		st_reg.rx_st && frame_overflow |=> last_interrupt_latch [*2] or
		                                   (last_interrupt_latch ##1 $past(int_clear));
	endproperty
	a_latch: assert property (p_latch) else $error("last interrupt lost");

	property p_fs_rw;
		io_write ##1 io_read && !io_write |=> extended_acc_bus == $past(acc_in, 2);
	endproperty
	a_fs_rw: assert property (p_fs_rw) else $error("frame size readback wrong");

	c_sync:   cover property (hit);
	c_tx_ld:  cover property (st_reg.tx_st && memory_load_strobe ##[1:100] shift);
	c_rx_end: cover property (st_reg.rx_st && transfer_done);
	c_par:    cover property (st_reg.tx_st && st_reg.out_sel && shift);

endmodule

// *** sim/ssld_modem_model.sv ***
`timescale 1ns/10ps
module ssld_modem_model #(
	parameter int TX_HALF = 64
) (
	output logic modem_receive_clock,
	output logic modem_transmit_clock,
	output logic receive_line,
	output logic clear_to_send,
	output logic set_ready,
	output logic carrier_detect
);
	initial begin
		modem_receive_clock = 1'b0;
		receive_line = 1'b1;
		clear_to_send = 1'b0;
		set_ready = 1'b0;
		carrier_detect = 1'b0;
	end

	// transmit clock never stops, even outside frames
	initial begin
		modem_transmit_clock = 1'b0;
		forever #(TX_HALF) modem_transmit_clock = ~modem_transmit_clock;
	end

	task automatic set_lines(input logic cts, input logic dsr, input logic dcd);
		clear_to_send = cts;
		set_ready = dsr;
		carrier_detect = dcd;
	endtask

	// data settles before the rising clock; after hold it flips so stale data never looks valid
	task automatic send_bit(input logic b);
		receive_line = b;
		#24;
		modem_receive_clock = 1'b1;
		#48;
		modem_receive_clock = 1'b0;
		#16;
		receive_line = ~b;
	endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/10ps
module testbench;
	import ssld_pkg::*;
	logic            core_clk, rst_n, rclk, tclk, rxd, cts, dsr, dcd;
	logic            rts, trdy, hunt, mls, tdone, fovf, pbit, psel, iclr, iow, ior;
	logic [SR_W-1:0] mword, sr, expv, w1;
	logic [FS_W-1:0] acc, fsf, xbus;
	logic            txl, xst, rst_st, latch, smatch, sstb, b, old;
	int              errors, cmp_count, stb_cnt, syn_cnt, seed, i, j, n0;

	ssld_top ssld_top_inst (.core_clk(core_clk), .rst_n(rst_n),
		.modem_receive_clock(rclk), .modem_transmit_clock(tclk), .receive_line(rxd),
		.clear_to_send(cts), .set_ready(dsr), .carrier_detect(dcd),
		.request_to_send(rts), .terminal_ready(trdy), .sync_hunt(hunt),
		.memory_load_strobe(mls), .memory_word(mword), .transfer_done(tdone),
		.frame_overflow(fovf), .parity_bit(pbit), .parity_select(psel), .int_clear(iclr),
		.io_write(iow), .io_read(ior), .acc_in(acc), .serdes_register(sr),
		.transmit_line(txl), .transmit_state_ff(xst), .receive_state_ff(rst_st),
		.last_interrupt_latch(latch), .sync_match(smatch), .shift_strobe(sstb),
		.frame_size_field(fsf), .extended_acc_bus(xbus));
	ssld_modem_model ssld_modem_model_inst (.modem_receive_clock(rclk),
		.modem_transmit_clock(tclk), .receive_line(rxd), .clear_to_send(cts),
		.set_ready(dsr), .carrier_detect(dcd));

	// ---------------------------------------------------------------
	// clock, counters, helpers
	// ---------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (sstb === 1'b1) stb_cnt++;
		if (smatch === 1'b1) syn_cnt++;
	end
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk_vec(input string nm, input logic [11:0] e, input logic [11:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	// one shift toward the last stage, new bit entering the first stage
	function automatic logic [11:0] exp_shift(input logic [11:0] v, input logic bit_in);
		return {bit_in, v[11:1]};
	endfunction
	// line carries parity when selected, else the buffered last stage
	function automatic logic exp_line(input logic sel_v, input logic par_v, input logic dat_v);
		return sel_v ? par_v : dat_v;
	endfunction
	task automatic wait_strobe();
		int n;
		n = 0;
		do begin
			tick();
			n++;
		end while (sstb !== 1'b1 && n < 40);
		if (sstb !== 1'b1) errors++;
	endtask
	localparam int P_DONE = 0;
	localparam int P_OVF  = 1;
	localparam int P_ICLR = 2;
	task automatic pulse(input int k);
		tdone = (k == P_DONE);
		fovf  = (k == P_OVF);
		iclr  = (k == P_ICLR);
		tick();
		tdone = 1'b0;
		fovf  = 1'b0;
		iclr  = 1'b0;
		tick();
	endtask
	task automatic final_report();
		if (errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		final_report();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		seed = 32'hc74d_66f7;
		{rst_n, rts, trdy, hunt, mls, tdone, fovf, pbit, psel, iclr, iow, ior} = '0;
		mword = '0;
		acc = '0;
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) tick();
		chk_vec("fs reset", {8'h00, FS_RESET}, {8'h00, fsf});
		for (i = 0; i < 4; i++) begin
			acc = $random(seed);
			iow = 1'b1;
			tick();
			iow = 1'b0;
			ior = 1'b1;
			chk_vec("fs", {8'h00, acc}, {8'h00, fsf});
			tick();
			ior = 1'b0;
			chk_vec("ext bus", {8'h00, acc}, {8'h00, xbus});
			tick();
			chk_vec("ext bus idle", 12'h000, {8'h00, xbus});
		end
		rts = 1'b1;
		trdy = 1'b1;
		ssld_modem_model_inst.set_lines(1'b1, 1'b1, 1'b1);
		repeat (8) tick();
		chk_bit("xmt", 1'b1, xst);
		wait_strobe();
		// preload so the end-of-character clear has ones to remove
		w1 = $random(seed);
		mword = w1;
		mls = 1'b1;
		tick();
		// clear outranks a load in the same cycle
		fovf = 1'b1;
		tick();
		fovf = 1'b0;
		chk_vec("clr", 12'h000, sr);
		tick();
		chk_vec("load", w1, sr);
		mword = $random(seed);
		expv = w1 | mword;
		tick();
		mls = 1'b0;
		chk_vec("or load", expv, sr);
		for (i = 0; i < 6; i++) begin
			psel = (i >= 4);
			pbit = $random(seed);
			old = expv[0];
			wait_strobe();
			expv = exp_shift(expv, 1'b0);
			tick();
			chk_vec("tx shift", expv, sr);
			chk_bit("tx line", exp_line(psel, pbit, old), txl);
		end
		trdy = 1'b0;
		repeat (8) tick();
		chk_bit("xmt drop", 1'b0, xst);
		rts = 1'b0;
		ssld_modem_model_inst.set_lines(1'b0, 1'b1, 1'b1);
		repeat (8) tick();
		chk_bit("rec", 1'b1, rst_st);
		chk_bit("rec line", 1'b0, txl);
		w1 = $random(seed);
		mword = w1;
		mls = 1'b1;
		tick();
		mls = 1'b0;
		chk_vec("rx load", w1, sr);
		pulse(P_DONE);
		chk_vec("rec clr", 12'h000, sr);
		expv = '0;
		n0 = stb_cnt;
		for (i = 0; i < 10; i++) begin
			b = $random(seed);
			ssld_modem_model_inst.send_bit(b);
			expv = exp_shift(expv, b);
			chk_vec("rx shift", expv, sr);
		end
		chk_vec("strobes", 12'h00a, 12'(stb_cnt - n0));
		pulse(P_DONE);
		hunt = 1'b1;
		n0 = syn_cnt;
		// sender opens with four sync characters
		for (i = 0; i < 4; i++) for (j = 0; j < 8; j++) ssld_modem_model_inst.send_bit(SYN_CODE[j]);
		b = $random(seed);
		ssld_modem_model_inst.send_bit(b);
		hunt = 1'b0;
		chk_vec("sync sr", {b, 11'h000}, sr);
		chk_vec("sync cnt", 12'h004, 12'(syn_cnt - n0));
		pulse(P_OVF);
		chk_bit("latch", 1'b1, latch);
		pulse(P_ICLR);
		chk_bit("latch clr", 1'b0, latch);
		final_report();
	end
endmodule
